/* File: interrupt_routing_serial_irq.sv */
// interrupt routing to pci int lines, isa irq outputs and the serialized irq wire
// assumes an apb master on core_clk_i, sources synchronous, serial line clocked by core_clk_i
// Overview of operation
// [RULE_01] default: card bridge on INTA, link on INTB, flash card on INTC.
// [RULE_02] link select upper bit 0 gives INTB, 1 gives INTA; card stays INTA.
// [RULE_03] flash select: 00 none, 01 INTC, 10 INTB, 11 INTA.
// [RULE_04] isa enable routes both 16-bit and 32-bit card interrupts to IRQx.
// [RULE_05] isa-route disable sends 32-bit card function interrupt to PCI line.
// [RULE_06] card status change goes to the isa irq its configuration names.
// [RULE_07] link interrupts never reach the isa irq outputs.
// [RULE_08] link events are sticky flags; only masked-in flags interrupt.
// [RULE_09] writing ones to the event clear register clears those link flags.
// [RULE_10] flash card insertion, removal and error each raise an interrupt.
// [RULE_11] pci interrupt pins are only pulled low or released.
// [RULE_12] each isa irq output is rising-edge or level, by configuration.
// [RULE_13] serial enable (default on) claims shared pin, enables gpio and led.
// [RULE_14] a serial cycle is start frame, irq/data frames, stop frame.
// [RULE_15] pci frames follow iochck frame unless their disable bit is set.
// [RULE_16] quiet mode: pending request drives line low one clock, then floats.
// [RULE_17] continuous mode: wait for a host start pulse 4 to 8 clocks.
// [RULE_18] stop pulse 2 clocks selects quiet, 3 clocks selects continuous.
// [RULE_19] after reset the serial logic is in continuous mode.
// [RULE_20] frame k sampled 2+3k clocks after start; last clock 95.
// [RULE_21] host may idle in stop frame and delay the next start.
// [RULE_22] all serial frame timing counts core clock cycles.
// [RULE_23] drive low at sample when asserted, high at recovery, else float.
`timescale 1ns/10ps
`include "irq_route_defs.svh"

module interrupt_routing_serial_irq #(
	parameter int ISA_IRQ_COUNT = 16
) (
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	output logic      [31:0]          prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	input  wire logic                 card_func_int_i,
	input  wire logic                 card_is_32bit_i,
	input  wire logic                 card_csc_int_i,
	input  wire logic                 link_dma_event_i,
	input  wire logic                 link_layer_event_i,
	input  wire logic                 link_phy_event_i,
	input  wire logic                 flash_card_present_i,
	input  wire logic                 flash_error_i,
	input  wire logic [2:0]           pci_int_in_i,
	output logic      [2:0]           pci_int_out_o,
	output logic      [2:0]           pci_int_oe_o,
	output logic      [ISA_IRQ_COUNT-1:0] isa_irq_o,
	input  wire logic                 serial_irq_line_in_i,
	output logic                      serial_irq_line_out_o,
	output logic                      serial_irq_line_oe_o,
	output logic                      gpio_function_enable_o,
	output logic                      activity_led_enable_o
);
	import irq_route_pkg::*;

	if (ISA_IRQ_COUNT != 16) begin : g_bad_count
		$error("isa irq count must be 16 to match the serial frame map");
	end

	// reset release through two flops
	logic       rst_meta_reg;
	logic       rst_sync_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire rst_n = rst_sync_reg;

	// apb decode
	logic [1:0]  link_sel_reg;
	logic [1:0]  flash_sel_reg;
	logic        isa_route_enable_reg;
	logic        serial_pci_int_frames_disable_reg;
	logic        card_func_isa_route_disable_reg;
	logic        serial_irq_enable_reg;
	logic [3:0]  card_irq_sel_reg;
	logic [3:0]  csc_irq_sel_reg;
	logic [15:0] isa_edge_reg;
	logic [2:0]  link_event_reg;
	logic [2:0]  link_mask_reg;
	logic [2:0]  flash_event_reg;
	logic [2:0]  flash_mask_reg;
	logic        flash_present_reg;
	logic [31:0] prdata_reg;
	logic        cont_mode_reg;
	logic [2:0]  pci_assert_reg;
	logic [15:0] isa_irq_reg;
	ser_state_type ser_state_reg;

	wire setup_phase  = psel_i & ~penable_i;
	wire access_phase = psel_i & penable_i;
	wire hit_route    = paddr_i == `OFS_ROUTE;
	wire hit_misc     = paddr_i == `OFS_MISC;
	wire hit_isa_cfg  = paddr_i == `OFS_ISA_CFG;
	wire hit_lev      = paddr_i == `OFS_LINK_EVENT;
	wire hit_lclr     = paddr_i == `OFS_LINK_EVENT_CLEAR;
	wire hit_lmask    = paddr_i == `OFS_LINK_MASK;
	wire hit_flash    = paddr_i == `OFS_FLASH_EVENT;
	wire hit_status   = paddr_i == `OFS_STATUS;
	wire hit_isa_st   = paddr_i == `OFS_ISA_STATUS;
	wire hit_any      = hit_route | hit_misc | hit_isa_cfg | hit_lev | hit_lclr | hit_lmask
	                  | hit_flash | hit_status | hit_isa_st;
	wire wr_access    = access_phase & pwrite_i & hit_any;
	wire wr_route     = wr_access & hit_route;
	wire wr_misc      = wr_access & hit_misc;
	wire wr_isa_cfg   = wr_access & hit_isa_cfg;
	wire wr_lclr      = wr_access & hit_lclr;
	wire wr_lmask     = wr_access & hit_lmask;
	wire wr_flash     = wr_access & hit_flash;

	// zero wait states; unmapped addresses answer with an error
	assign pready_o  = 1'b1;
	assign pslverr_o = access_phase & ~hit_any;
	assign prdata_o  = prdata_reg;

	wire [31:0] rd_route  = {5'h00, flash_sel_reg, 23'h000000, link_sel_reg};
	wire [31:0] rd_misc   = {24'h000000, serial_irq_enable_reg, card_func_isa_route_disable_reg,
	                         serial_pci_int_frames_disable_reg, 4'h0, isa_route_enable_reg};
	wire [31:0] rd_isa    = {isa_edge_reg, 8'h00, csc_irq_sel_reg, card_irq_sel_reg};
	wire [31:0] rd_flash  = {21'h000000, flash_mask_reg, 5'h00, flash_event_reg};
	wire [31:0] rd_status = {20'h00000, ser_state_reg != SER_IDLE, 4'h0, ~pci_int_in_i,
	                         pci_assert_reg, cont_mode_reg};
	wire [31:0] rd_mux    = hit_route  ? rd_route :
	                        hit_misc   ? rd_misc :
	                        hit_isa_cfg ? rd_isa :
	                        hit_lev    ? {29'h00000000, link_event_reg} :
	                        hit_lmask  ? {29'h00000000, link_mask_reg} :
	                        hit_flash  ? rd_flash :
	                        hit_status ? rd_status :
	                        hit_isa_st ? {16'h0000, isa_irq_reg} : 32'h00000000;

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= 32'h00000000;
		end else if (setup_phase & ~pwrite_i) begin
			prdata_reg <= rd_mux;
		end
	end

	// configuration registers
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			link_sel_reg  <= `LINK_SEL_RESET; // RULE_01
			flash_sel_reg <= `FLASH_SEL_RESET; // RULE_01
		end else if (wr_route) begin
			link_sel_reg  <= pwdata_i[`ROUTE_LINK_SEL_LSB +: 2];
			flash_sel_reg <= pwdata_i[`ROUTE_FLASH_SEL_LSB +: 2];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			isa_route_enable_reg              <= 1'b0;
			serial_pci_int_frames_disable_reg <= 1'b0;
			card_func_isa_route_disable_reg   <= 1'b0;
			serial_irq_enable_reg             <= `SER_EN_RESET; // RULE_13
		end else if (wr_misc) begin
			isa_route_enable_reg              <= pwdata_i[`MISC_ISA_EN_BIT];
			serial_pci_int_frames_disable_reg <= pwdata_i[`MISC_SER_PCI_DIS_BIT];
			card_func_isa_route_disable_reg   <= pwdata_i[`MISC_CINT_ISA_DIS_BIT];
			serial_irq_enable_reg             <= pwdata_i[`MISC_SER_EN_BIT];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			card_irq_sel_reg <= 4'h0;
			csc_irq_sel_reg  <= 4'h0;
			isa_edge_reg     <= 16'h0000;
		end else if (wr_isa_cfg) begin
			card_irq_sel_reg <= pwdata_i[`ISA_CARD_SEL_LSB +: 4];
			csc_irq_sel_reg  <= pwdata_i[`ISA_CSC_SEL_LSB +: 4];
			isa_edge_reg     <= pwdata_i[`ISA_EDGE_LSB +: 16];
		end
	end

	// link event flags: a new event wins over a clear in the same cycle
	wire [2:0] link_set = {link_phy_event_i, link_layer_event_i, link_dma_event_i};
	wire [2:0] link_clr = wr_lclr ? pwdata_i[2:0] : 3'h0;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			link_event_reg <= 3'h0;
			link_mask_reg  <= `LINK_MASK_RESET;
		end else begin
			link_event_reg <= (link_event_reg & ~link_clr) | link_set; // RULE_08 RULE_09
			if (wr_lmask) begin
				link_mask_reg <= pwdata_i[2:0];
			end
		end
	end
	wire link_irq = |(link_event_reg & link_mask_reg); // RULE_08

	// flash card events: insert, remove, error; write one to clear
	wire       flash_insert = flash_card_present_i & ~flash_present_reg;
	wire       flash_remove = ~flash_card_present_i & flash_present_reg;
	wire [2:0] flash_set    = {flash_error_i, flash_remove, flash_insert};
	wire [2:0] flash_clr    = wr_flash ? pwdata_i[2:0] : 3'h0;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			flash_present_reg <= 1'b0;
			flash_event_reg   <= 3'h0;
			flash_mask_reg    <= `FLASH_MASK_RESET;
		end else begin
			flash_present_reg <= flash_card_present_i;
			flash_event_reg   <= (flash_event_reg & ~flash_clr) | flash_set; // RULE_10
			if (wr_flash) begin
				flash_mask_reg <= pwdata_i[`FLASH_MASK_LSB +: 3];
			end
		end
	end
	wire flash_irq = |(flash_event_reg & flash_mask_reg); // RULE_10

	// card bridge routing between isa and pci
	wire card_to_isa = isa_route_enable_reg & ~(card_is_32bit_i & card_func_isa_route_disable_reg); // RULE_04 RULE_05
	wire csc_to_isa  = isa_route_enable_reg & (csc_irq_sel_reg != 4'h0); // RULE_06
	wire card_pci    = (card_func_int_i & ~card_to_isa) | (card_csc_int_i & ~csc_to_isa);

	// link select uses only its upper bit; card bridge is fixed on line a
	wire [2:0] pci_assert_next;
	assign pci_assert_next[PCI_LINE_A] = card_pci | (link_irq & link_sel_reg[1]) // RULE_02
	                                   | (flash_irq & (flash_sel_reg == 2'h3)); // RULE_03
	assign pci_assert_next[PCI_LINE_B] = (link_irq & ~link_sel_reg[1]) // RULE_02
	                                   | (flash_irq & (flash_sel_reg == 2'h2)); // RULE_03
	assign pci_assert_next[PCI_LINE_C] = flash_irq & (flash_sel_reg == 2'h1); // RULE_03

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pci_assert_reg <= 3'h0;
		end else begin
			pci_assert_reg <= pci_assert_next;
		end
	end
	// open drain: the data is always low, only the enable moves
	assign pci_int_out_o = 3'h0; // RULE_11
	assign pci_int_oe_o  = pci_assert_reg; // RULE_11

	// isa irq outputs; only card sources feed them, never the link
	logic [15:0] isa_src_prev_reg;
	wire  [15:0] isa_src;
	for (genvar i = 0; i < ISA_IRQ_COUNT; i++) begin : g_isa
		assign isa_src[i] = (card_func_int_i & card_to_isa & (card_irq_sel_reg == 4'(i))) // RULE_04 RULE_07
		                  | (card_csc_int_i & csc_to_isa & (csc_irq_sel_reg == 4'(i))); // RULE_06
		always_ff @(posedge core_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				isa_src_prev_reg[i] <= 1'b0;
				isa_irq_reg[i]      <= 1'b0;
			end else begin
				isa_src_prev_reg[i] <= isa_src[i];
				isa_irq_reg[i]      <= isa_edge_reg[i] ? (isa_src[i] & ~isa_src_prev_reg[i]) : isa_src[i]; // RULE_12
			end
		end
	end
	assign isa_irq_o = isa_irq_reg;

	// serial frame contents: 16 isa irqs, iochck, then pci a..d
	wire [20:0] frame_vec   = {1'b0, pci_assert_reg, 1'b0, isa_src};
	wire [4:0]  frame_total = serial_pci_int_frames_disable_reg ? `SER_FRAMES_ISA : `SER_FRAMES_ALL; // RULE_15
	wire [6:0]  frame_end   = 7'(`SER_FIRST_SAMPLE + `SER_FRAME_CLKS * 7'(frame_total));

	assign gpio_function_enable_o = serial_irq_enable_reg; // RULE_13
	assign activity_led_enable_o  = serial_irq_enable_reg; // RULE_13

	// serial irq engine; the line is sampled every core clock
	ser_state_type ser_state_next;
	logic [3:0]  low_cnt_reg;
	logic [3:0]  low_cnt_next;
	logic [6:0]  clk_cnt_reg;
	logic [6:0]  clk_cnt_next;
	logic        cont_mode_next;
	logic        ser_out_reg;
	logic        ser_out_next;
	logic        ser_oe_reg;
	logic        ser_oe_next;
	logic [20:0] sent_vec_reg;
	logic [20:0] sent_vec_next;
	logic [6:0]  slot_off;
	logic [6:0]  slot_frame;
	logic [6:0]  slot_phase;

	wire line_low    = ~serial_irq_line_in_i;
	wire low_cnt_inc = low_cnt_reg != 4'hf;
	wire pending     = frame_vec != sent_vec_reg; // quiet start only on a change, else it would loop

	always_comb begin
		ser_state_next = ser_state_reg;
		low_cnt_next   = low_cnt_reg;
		clk_cnt_next   = clk_cnt_reg;
		cont_mode_next = cont_mode_reg;
		sent_vec_next  = sent_vec_reg;
		ser_out_next   = 1'b1;
		ser_oe_next    = 1'b0;
		slot_off       = 7'h00;
		slot_frame     = 7'h00;
		slot_phase     = 7'h00;
		case (ser_state_reg)
		SER_IDLE: begin
			low_cnt_next = 4'h0;
			if (line_low) begin
				ser_state_next = SER_START_LOW; // RULE_14
				low_cnt_next   = 4'h1;
			end else if (!cont_mode_reg && pending) begin
				ser_state_next = SER_QSTART; // RULE_16
				ser_out_next   = 1'b0;
				ser_oe_next    = 1'b1;
			end
		end
		SER_QSTART: begin
			ser_state_next = SER_START_LOW; // RULE_16
			low_cnt_next   = 4'h1;
		end
		SER_START_LOW: begin
			if (line_low) begin
				low_cnt_next = low_cnt_reg + 4'(low_cnt_inc); // RULE_22
			end else if (cont_mode_reg ? (low_cnt_reg >= `SER_START_MIN && low_cnt_reg <= `SER_START_MAX)
			                           : (low_cnt_reg != 4'h0)) begin // RULE_17
				ser_state_next = SER_FRAMES;
				clk_cnt_next   = 7'h01;
				sent_vec_next  = frame_vec;
			end else begin
				ser_state_next = SER_IDLE;
			end
		end
		SER_FRAMES: begin
			clk_cnt_next = clk_cnt_reg + 7'h01; // RULE_22
			slot_off     = clk_cnt_next - `SER_FIRST_SAMPLE;
			slot_frame   = slot_off / `SER_FRAME_CLKS; // RULE_20
			slot_phase   = slot_off % `SER_FRAME_CLKS;
			if (clk_cnt_next >= frame_end || clk_cnt_next > `SER_LAST_CLOCK) begin
				ser_state_next = SER_STOP_WAIT; // RULE_14
				low_cnt_next   = 4'h0;
			end else if (clk_cnt_next >= `SER_FIRST_SAMPLE && frame_vec[5'(slot_frame)]) begin
				ser_oe_next  = slot_phase != 7'h02; // RULE_23
				ser_out_next = slot_phase != 7'h00; // RULE_23
			end
		end
		SER_STOP_WAIT: begin
			// idle states before the stop pulse are tolerated
			if (line_low) begin
				low_cnt_next = low_cnt_reg + 4'(low_cnt_inc); // RULE_21
			end else if (low_cnt_reg != 4'h0) begin
				ser_state_next = SER_IDLE; // RULE_21
				if (low_cnt_reg == `SER_STOP_QUIET) begin
					cont_mode_next = 1'b0; // RULE_18
				end else if (low_cnt_reg == `SER_STOP_CONT) begin
					cont_mode_next = 1'b1; // RULE_18
				end
			end
		end
		default: begin
			ser_state_next = SER_IDLE;
		end
		endcase
		if (!serial_irq_enable_reg) begin
			ser_state_next = SER_IDLE; // RULE_13
			ser_oe_next    = 1'b0;
			ser_out_next   = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ser_state_reg <= SER_IDLE;
			low_cnt_reg   <= 4'h0;
			clk_cnt_reg   <= 7'h00;
			cont_mode_reg <= 1'b1; // RULE_19
			ser_out_reg   <= 1'b1;
			ser_oe_reg    <= 1'b0;
			sent_vec_reg  <= 21'h000000;
		end else begin
			ser_state_reg <= ser_state_next;
			low_cnt_reg   <= low_cnt_next;
			clk_cnt_reg   <= clk_cnt_next;
			cont_mode_reg <= cont_mode_next;
			ser_out_reg   <= ser_out_next;
			ser_oe_reg    <= ser_oe_next;
			sent_vec_reg  <= sent_vec_next;
		end
	end
	assign serial_irq_line_out_o = ser_out_reg;
	assign serial_irq_line_oe_o  = ser_oe_reg;

endmodule : interrupt_routing_serial_irq

/* File: irq_route_checker.sv */
// checker for the pci pins, isa outputs, apb error and serial wire drive
// assumes binding onto the routing top module, one clock domain
`timescale 1ns/10ps
module irq_route_checker #(
	parameter int ISA_IRQ_COUNT = 16
) (
	input wire logic                     core_clk_i,
	input wire logic                     rst_n_i,
	input wire logic                     psel_i,
	input wire logic                     penable_i,
	input wire logic [7:0]               paddr_i,
	input wire logic                     pslverr_o,
	input wire logic                     card_func_int_i,
	input wire logic                     card_csc_int_i,
	input wire logic [2:0]               pci_int_out_o,
	input wire logic [ISA_IRQ_COUNT-1:0] isa_irq_o,
	input wire logic                     serial_irq_line_out_o,
	input wire logic                     serial_irq_line_oe_o,
	input wire logic                     gpio_function_enable_o,
	input wire logic                     activity_led_enable_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire drv_lo = serial_irq_line_oe_o && !serial_irq_line_out_o;
	wire drv_hi = serial_irq_line_oe_o && serial_irq_line_out_o;
	sequence recover_s;
		drv_hi ##1 !serial_irq_line_oe_o;
	endsequence
	pci_low_only_a: assert property (pci_int_out_o == 3'h0)
		else $error("pci pin driven high");
	led_pair_a: assert property (gpio_function_enable_o == activity_led_enable_o)
		else $error("gpio and led enables differ");
	serial_off_a: assert property (!gpio_function_enable_o && !$past(gpio_function_enable_o)
		&& !$past(gpio_function_enable_o, 2) |-> !serial_irq_line_oe_o) else $error("serial wire driven while off");
	recover_float_a: assert property (drv_hi |=> !serial_irq_line_oe_o)
		else $error("no float after recovery");
	frame_spacing_a: assert property (recover_s |=> !drv_hi)
		else $error("frame shorter than three clocks");
	low_pulse_a: assert property (drv_lo |=> drv_hi || !serial_irq_line_oe_o)
		else $error("low drive not followed by recovery or float");
	isa_quiet_a: assert property (!card_func_int_i && !card_csc_int_i && !$past(card_func_int_i)
		&& !$past(card_csc_int_i) |-> isa_irq_o == '0) else $error("isa output without card source");
	err_access_a: assert property (pslverr_o |-> psel_i && penable_i)
		else $error("slave error outside access phase");
	mapped_ok_a: assert property (psel_i && penable_i && paddr_i <= 8'h20 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
		else $error("slave error on mapped address");
endmodule : irq_route_checker

bind interrupt_routing_serial_irq irq_route_checker #(.ISA_IRQ_COUNT(ISA_IRQ_COUNT)) chk (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.paddr_i(paddr_i), .pslverr_o(pslverr_o), .card_func_int_i(card_func_int_i),
	.card_csc_int_i(card_csc_int_i), .pci_int_out_o(pci_int_out_o), .isa_irq_o(isa_irq_o),
	.serial_irq_line_out_o(serial_irq_line_out_o), .serial_irq_line_oe_o(serial_irq_line_oe_o),
	.gpio_function_enable_o(gpio_function_enable_o), .activity_led_enable_o(activity_led_enable_o));

/* File: irq_route_defs.svh */
// register offsets, field positions, reset values and serial frame counts
// assumes inclusion by the design file and the bench only
`ifndef IRQ_ROUTE_DEFS_SVH
`define IRQ_ROUTE_DEFS_SVH

`define OFS_ROUTE            8'h00
`define OFS_MISC             8'h04
`define OFS_ISA_CFG          8'h08
`define OFS_LINK_EVENT       8'h0c
`define OFS_LINK_EVENT_CLEAR 8'h10
`define OFS_LINK_MASK        8'h14
`define OFS_FLASH_EVENT      8'h18
`define OFS_STATUS           8'h1c
`define OFS_ISA_STATUS       8'h20

`define ROUTE_LINK_SEL_LSB   0
`define ROUTE_FLASH_SEL_LSB  25
`define MISC_ISA_EN_BIT      0
`define MISC_SER_PCI_DIS_BIT 5
`define MISC_CINT_ISA_DIS_BIT 6
`define MISC_SER_EN_BIT      7
`define ISA_CARD_SEL_LSB     0
`define ISA_CSC_SEL_LSB      4
`define ISA_EDGE_LSB         16
`define FLASH_MASK_LSB       8

`define LINK_SEL_RESET       2'h0
`define FLASH_SEL_RESET      2'h1
`define SER_EN_RESET         1'h1
`define LINK_MASK_RESET      3'h0
`define FLASH_MASK_RESET     3'h0

`define SER_START_MIN        4'h4
`define SER_START_MAX        4'h8
`define SER_STOP_QUIET       4'h2
`define SER_STOP_CONT        4'h3
`define SER_FIRST_SAMPLE     7'h02
`define SER_FRAME_CLKS       7'h03
`define SER_FRAMES_ISA       5'h11
`define SER_FRAMES_ALL       5'h15
`define SER_LAST_CLOCK       7'h5f
`endif

/* File: irq_route_pkg.sv */
// types shared by the interrupt routing and serial irq block
// assumes the defs header sits in the same folder
package irq_route_pkg;
	typedef enum logic [2:0] {
		SER_IDLE,
		SER_QSTART,
		SER_START_LOW,
		SER_FRAMES,
		SER_STOP_WAIT
	} ser_state_type;

	typedef enum logic [1:0] {
		PCI_LINE_A,
		PCI_LINE_B,
		PCI_LINE_C,
		PCI_LINE_D
	} pci_line_type;
endpackage : irq_route_pkg

/* File: serial_irq_host.sv */
// host controller on the serialized irq wire: start pulse, frame sampling, stop pulse
// assumes the bench resolves the wire with a pull-up and feeds it back on line_i
`timescale 1ns/10ps
module serial_irq_host (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       go_i,
	input  wire logic [3:0] start_w_i,
	input  wire logic [3:0] stop_w_i,
	input  wire logic [4:0] frames_i,
	input  wire logic       line_i,
	output logic            drive_low_o,
	output logic            busy_o,
	output logic [20:0]     seen_o
);
	logic [1:0] phase_reg;
	logic [6:0] cnt_reg;
	assign busy_o = phase_reg != 2'h0;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_reg   <= 2'h0;
			cnt_reg     <= 7'h00;
			drive_low_o <= 1'b0;
			seen_o      <= 21'h0;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
			case (phase_reg)
			2'h0: if (go_i || !line_i) begin
				phase_reg   <= 2'h1;
				cnt_reg     <= 7'h01;
				drive_low_o <= 1'b1;
				seen_o      <= 21'h0;
			end
			2'h1: if (cnt_reg == 7'(start_w_i)) begin
				phase_reg   <= 2'h2;
				cnt_reg     <= 7'h00;
				drive_low_o <= 1'b0;
			end
			2'h2: begin
				if (cnt_reg % 7'h03 == 7'h02 && cnt_reg / 7'h03 < 7'(frames_i))
					seen_o[cnt_reg / 7'h03] <= !line_i;
				if (cnt_reg == 7'h03 * 7'(frames_i) + 7'h01) begin
					phase_reg   <= 2'h3;
					cnt_reg     <= 7'h01;
					drive_low_o <= 1'b1;
				end
			end
			default: if (cnt_reg == 7'(stop_w_i)) begin
				phase_reg   <= 2'h0;
				drive_low_o <= 1'b0;
			end
			endcase
		end
	end
endmodule : serial_irq_host

/* File: testbench.sv */
// bench for the routing block: apb tasks and a host model on the serial wire
// assumes design, package, checker and host model are compiled first
`timescale 1ns/10ps
`include "irq_route_defs.svh"
module testbench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rdat, prdata;
	logic        rerr, pready, pslverr, ser_out, ser_oe, gpio_en, led_en, host_lo, hbusy;
	logic        cfi = 1'b0, c32 = 1'b0, csc = 1'b0, fpres = 1'b0, ferr = 1'b0, go = 1'b0;
	logic [2:0]  lev = 3'h0;
	logic [3:0]  sw = 4'h4, pw = 4'h3;
	logic [4:0]  nf = 5'h11;
	logic [2:0]  pci_out, pci_oe;
	logic [15:0] isa;
	logic [20:0] seen;
	logic [2:0]  lexp [4] = '{3'h3, 3'h3, 3'h1, 3'h1};
	logic [2:0]  fexp [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
	int          err_total = 0;
	int          samples_checked = 0;
	wire         ser_line = host_lo ? 1'b0 : (ser_oe ? ser_out : 1'b1);
	always #12.5 clk = ~clk;
	interrupt_routing_serial_irq dut (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .card_func_int_i(cfi), .card_is_32bit_i(c32), .card_csc_int_i(csc),
		.link_dma_event_i(lev[0]), .link_layer_event_i(lev[1]), .link_phy_event_i(lev[2]),
		.flash_card_present_i(fpres), .flash_error_i(ferr), .pci_int_in_i(~pci_oe),
		.pci_int_out_o(pci_out), .pci_int_oe_o(pci_oe), .isa_irq_o(isa), .serial_irq_line_in_i(ser_line),
		.serial_irq_line_out_o(ser_out), .serial_irq_line_oe_o(ser_oe),
		.gpio_function_enable_o(gpio_en), .activity_led_enable_o(led_en));
	serial_irq_host host (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .start_w_i(sw), .stop_w_i(pw),
		.frames_i(nf), .line_i(ser_line), .drive_low_o(host_lo), .busy_o(hbusy), .seen_o(seen));
	task check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a wait that never completes
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(rdat & m, exp);
	endtask : rd
	task settle(input int n);
		repeat (n) @(posedge clk);
	endtask : settle
	task link_pulse;
		lev <= 3'h7;
		@(posedge clk);
		lev <= 3'h0;
		settle(3);
	endtask : link_pulse
	task host_cycle(input logic g, input logic [3:0] s, input logic [3:0] p, input logic [4:0] f);
		@(posedge clk);
		go <= g;
		sw <= s;
		pw <= p;
		nf <= f;
		@(posedge clk);
		go <= 1'b0;
		while (hbusy !== 1'b1) begin
			@(posedge clk);
		end
		while (hbusy === 1'b1) begin
			@(posedge clk);
		end
		settle(3);
	endtask : host_cycle
	task print_verdict;
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict;
	end
	initial begin
		settle(4);
		rst_n <= 1'b1;
		settle(3);
		check(32'(gpio_en && led_en), 32'h1);
		rd(`OFS_ROUTE, 32'hffffffff, 32'h02000000);
		rd(`OFS_MISC, 32'h000000e1, 32'h00000080);
		rd(`OFS_STATUS, 32'h1, 32'h1);
		xfer(1'b0, 8'h24, 32'h0);
		check({rerr, rdat[30:0]}, 32'h80000000);
		cfi <= 1'b1;
		c32 <= 1'b1;
		link_pulse;
		check(32'(pci_oe), 32'h1);
		rd(`OFS_LINK_EVENT, 32'h7, 32'h7);
		wr(`OFS_LINK_MASK, 32'h4);
		settle(2);
		check(32'(pci_oe), 32'h3);
		wr(`OFS_LINK_EVENT_CLEAR, 32'h4);
		rd(`OFS_LINK_EVENT, 32'h7, 32'h3);
		settle(2);
		check(32'(pci_oe), 32'h1);
		wr(`OFS_LINK_MASK, 32'h7);
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_ROUTE, 32'h02000000 | 32'(i));
			settle(2);
			check(32'(pci_oe), 32'(lexp[i]));
		end
		wr(`OFS_LINK_EVENT_CLEAR, 32'h7);
		rd(`OFS_LINK_EVENT, 32'h7, 32'h0);
		cfi <= 1'b0;
		wr(`OFS_FLASH_EVENT, 32'h700);
		fpres <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_ROUTE, 32'(i) << 25);
			settle(2);
			check(32'(pci_oe), 32'(fexp[i]));
		end
		wr(`OFS_FLASH_EVENT, 32'h707);
		fpres <= 1'b0;
		ferr  <= 1'b1;
		@(posedge clk);
		ferr <= 1'b0;
		rd(`OFS_FLASH_EVENT, 32'h7, 32'h6);
		wr(`OFS_FLASH_EVENT, 32'h7);
		wr(`OFS_ROUTE, 32'h02000000);
		wr(`OFS_MISC, 32'h81);
		wr(`OFS_ISA_CFG, 32'h95);
		cfi <= 1'b1;
		c32 <= 1'b0;
		settle(2);
		check({13'h0, pci_oe, isa}, 32'h20);
		c32 <= 1'b1;
		wr(`OFS_MISC, 32'hc1);
		settle(2);
		check({13'h0, pci_oe, isa}, 32'h10000);
		cfi <= 1'b0;
		wr(`OFS_ISA_CFG, 32'h02000095);
		csc <= 1'b1;
		settle(2);
		check(32'(isa), 32'h200);
		settle(1);
		check(32'(isa), 32'h0);
		csc <= 1'b0;
		wr(`OFS_ISA_CFG, 32'h95);
		csc <= 1'b1;
		settle(3);
		check(32'(isa), 32'h200);
		csc <= 1'b0;
		link_pulse;
		check(32'(isa), 32'h0);
		cfi <= 1'b1;
		c32 <= 1'b0;
		wr(`OFS_MISC, 32'h81);
		host_cycle(1'b1, 4'h4, 4'h3, 5'h15);
		check(32'(seen), 32'h40020);
		wr(`OFS_MISC, 32'ha1);
		host_cycle(1'b1, 4'h8, 4'h3, 5'h15);
		check(32'(seen), 32'h20);
		host_cycle(1'b1, 4'h3, 4'h3, 5'h15);
		check(32'(seen), 32'h0);
		host_cycle(1'b1, 4'h4, 4'h2, 5'h11);
		rd(`OFS_STATUS, 32'h1, 32'h0);
		csc <= 1'b1;
		host_cycle(1'b0, 4'h4, 4'h2, 5'h11);
		check(32'(seen), 32'h220);
		host_cycle(1'b1, 4'h4, 4'h3, 5'h11);
		rd(`OFS_STATUS, 32'h1, 32'h1);
		wr(`OFS_MISC, 32'h01);
		settle(3);
		check(32'(gpio_en || led_en), 32'h0);
		host_cycle(1'b1, 4'h4, 4'h3, 5'h11);
		check(32'(seen), 32'h0);
		print_verdict;
	end
endmodule : testbench
